// *** core/cerr_pkg.sv ***
/*
  Constants, types and helpers for the correctable error reporting block.
  Assumes a configuration-space access port that offers 12-bit byte offsets.
*/
//============================================================
package cerr_pkg;

  //============================================================
  // offsets
  localparam logic [11:0] CERR_SEV_OFS = 12'h10C;
  localparam logic [11:0] CERR_STAT_OFS = 12'h110;
  localparam logic [11:0] CERR_MASK_OFS = 12'h114;
  localparam logic [11:0] CERR_CAPS_OFS = 12'h118;

  //============================================================
  // reset values and field masks
  localparam logic [31:0] CERR_SEV_RST = 32'h0006_2031;
  localparam logic [31:0] CERR_SEV_RW = 32'h001F_F010;
  localparam logic [31:0] CERR_SEV_RO1 = 32'h0000_0021;
  localparam logic [31:0] CERR_STAT_RST = 32'h0000_0000;
  localparam logic [31:0] CERR_STAT_IMPL = 32'h0000_31C1;
  localparam logic [31:0] CERR_MASK_RST = 32'h0000_2000;
  localparam logic [31:0] CERR_CAPS_RST = 32'h0000_00A0;
  localparam logic [31:0] CERR_CAPS_RW = 32'h0000_0140;
  localparam logic [31:0] CERR_CAPS_RO1 = 32'h0000_00A0;

  //============================================================
  // field positions
  localparam int CERR_SEV_DLL_BIT = 4;
  localparam int CERR_CAPS_CHK_EN_BIT = 8;
  localparam int CERR_CAPS_GEN_EN_BIT = 6;
  localparam int CERR_CAPS_FEP_W = 5;
  localparam int CERR_ADV_BIT = 13;
  localparam int CERR_RTMO_BIT = 12;
  localparam int CERR_ROLL_BIT = 8;
  localparam int CERR_DLLP_BIT = 7;
  localparam int CERR_TLP_BIT = 6;
  localparam int CERR_RXE_BIT = 0;

  //============================================================
  // carriers
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cerr_cfg_req_t;

  typedef struct packed {
    logic advisory;
    logic replay_tmo;
    logic replay_roll;
    logic corrupt_link_packet_flag;
    logic corrupt_transaction_packet_flag;
    logic rx_err;
  } cerr_evt_t;

  //============================================================
  // helpers
  // byte enables widened to a bit mask
  function automatic logic [31:0] cerr_be_mask(input logic [3:0] be);
    cerr_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // writable bits take write data, the rest keep their value
  function automatic logic [31:0] cerr_merge(input logic [31:0] old_v,
      input logic [31:0] wd, input logic [31:0] en);
    cerr_merge = (old_v & ~en) | (wd & en);
  endfunction

  // detector pulses placed at their status bit positions
  function automatic logic [31:0] cerr_evt_vec(input cerr_evt_t e);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[CERR_ADV_BIT] = e.advisory;
    v[CERR_RTMO_BIT] = e.replay_tmo;
    v[CERR_ROLL_BIT] = e.replay_roll;
    v[CERR_DLLP_BIT] = e.corrupt_link_packet_flag;
    v[CERR_TLP_BIT] = e.corrupt_transaction_packet_flag;
    v[CERR_RXE_BIT] = e.rx_err;
    cerr_evt_vec = v;
  endfunction

  // status vector folded back into the event struct
  function automatic cerr_evt_t cerr_vec_evt(input logic [31:0] v);
    cerr_evt_t e;
    e.advisory = v[CERR_ADV_BIT];
    e.replay_tmo = v[CERR_RTMO_BIT];
    e.replay_roll = v[CERR_ROLL_BIT];
    e.corrupt_link_packet_flag = v[CERR_DLLP_BIT];
    e.corrupt_transaction_packet_flag = v[CERR_TLP_BIT];
    e.rx_err = v[CERR_RXE_BIT];
    cerr_vec_evt = e;
  endfunction

endpackage

// *** core/cerr_sync.sv ***
/*
  Two-stage level synchroniser.
  Assumes the input may change at any time relative to core_clk.
*/
`timescale 1ns/10ps
module cerr_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;

  //============================================================
  // first stage is read only by the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// *** core/cerr_flag.sv ***
/*
  One sticky write-one-to-clear status flag.
  Assumes set and clear come from logic on core_clk.
*/
`timescale 1ns/10ps
module cerr_flag (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_rst,
  // control
  input wire logic set,
  input wire logic clr,
  output logic flag_reg
);
  logic flag_next;

  // set over clear so a same-cycle event is never lost
  assign flag_next = set | (flag_reg & ~clr);

  //============================================================
  // flag storage, reset restores zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else if (soft_rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end
endmodule

// *** core/cerr_top.sv ***
/*
  Correctable error status and mask, tail of uncorrectable severity and
  the capabilities and control register, reached through configuration
  space. Assumes detectors pulse events on core_clk and that link and
  global reset pins are asynchronous to core_clk.
*/
`timescale 1ns/10ps
module cerr_top (
  // clock and power-on reset
  input wire logic core_clk,
  input wire logic rst,
  // reset pins
  input wire logic link_reset,
  input wire logic global_reset_input,
  // configuration access
  input wire cerr_pkg::cerr_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // detector events
  input wire cerr_pkg::cerr_evt_t evt_in,
  // first uncorrectable error from the uncorrectable logic
  input wire logic unc_first_load,
  input wire logic [4:0] unc_first_pos,
  // reporting
  output cerr_pkg::cerr_evt_t cor_report,
  output logic cor_msg_req,
  // control outputs
  output logic link_protocol_fault_fatal_sel,
  output logic crc_check_en,
  output logic crc_gen_en
);
  import cerr_pkg::*;

  logic link_rst_s;
  logic global_reset_input_s;
  logic soft_rst;
  logic [31:0] wmask;
  logic wr_sev;
  logic wr_stat;
  logic wr_mask;
  logic wr_caps;
  logic [31:0] sev_reg;
  logic [31:0] sev_next;
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic [31:0] caps_reg;
  logic [31:0] caps_next;
  logic [31:0] stat_q;
  logic [31:0] evt_vec;
  logic [31:0] live_vec;
  logic [31:0] clr_vec;
  logic [31:0] rd_word;
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  cerr_evt_t report_reg;
  logic msg_reg;

  //============================================================
  // reset pins
  // pins are synchronised first; their effect is a clocked clear
  cerr_sync u_sync_link (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(link_reset),
    .sync_out(link_rst_s)
  );

  cerr_sync u_sync_global_reset_input (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(global_reset_input),
    .sync_out(global_reset_input_s)
  );

  assign soft_rst = link_rst_s | global_reset_input_s;

  //============================================================
  // write decode
  assign wmask = cerr_be_mask(cfg_req.be);
  assign wr_sev = cfg_req.wr & (cfg_req.addr == CERR_SEV_OFS);
  assign wr_stat = cfg_req.wr & (cfg_req.addr == CERR_STAT_OFS);
  assign wr_mask = cfg_req.wr & (cfg_req.addr == CERR_MASK_OFS);
  assign wr_caps = cfg_req.wr & (cfg_req.addr == CERR_CAPS_OFS);

  //============================================================
  // next values; read-only and reserved bits never take write data
  assign sev_next = wr_sev ? cerr_merge(sev_reg, cfg_req.wdata, wmask & CERR_SEV_RW)
                           : sev_reg;
  assign mask_next = wr_mask ? cerr_merge(mask_reg, cfg_req.wdata, wmask & CERR_STAT_IMPL)
                             : mask_reg;
  assign caps_next = wr_caps ? cerr_merge(caps_reg, cfg_req.wdata, wmask & CERR_CAPS_RW)
                             : caps_reg;

  //============================================================
  // severity, mask and control storage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sev_reg <= CERR_SEV_RST & CERR_SEV_RW;
      mask_reg <= CERR_MASK_RST;
      caps_reg <= CERR_CAPS_RST & CERR_CAPS_RW;
    end else if (soft_rst) begin
      sev_reg <= CERR_SEV_RST & CERR_SEV_RW;
      mask_reg <= CERR_MASK_RST;
      caps_reg <= CERR_CAPS_RST & CERR_CAPS_RW;
    end else begin
      sev_reg <= sev_next;
      mask_reg <= mask_next;
      // pointer is loaded by hardware, never by a write
      caps_reg <= unc_first_load
          ? {caps_next[31:CERR_CAPS_FEP_W], unc_first_pos}
          : caps_next;
    end
  end

  //============================================================
  // status flags
  // masked events are dropped here, before they can reach any flag
  assign evt_vec = cerr_evt_vec(evt_in) & CERR_STAT_IMPL;
  assign live_vec = evt_vec & ~mask_reg;
  assign clr_vec = wr_stat ? (cfg_req.wdata & wmask & CERR_STAT_IMPL) : 32'h0000_0000;

  for (genvar i = 0; i < 32; i++) begin : g_flag
    if (CERR_STAT_IMPL[i]) begin : g_impl
      cerr_flag u_flag (
        .core_clk(core_clk),
        .rst(rst),
        .soft_rst(soft_rst),
        .set(live_vec[i]),
        .clr(clr_vec[i]),
        .flag_reg(stat_q[i])
      );
    end else begin : g_rsvd
      assign stat_q[i] = 1'b0;
    end
  end

  //============================================================
  // read mux; unmapped offsets read zero
  assign rd_word =
      (cfg_req.addr == CERR_SEV_OFS) ? (sev_reg | CERR_SEV_RO1) :
      (cfg_req.addr == CERR_STAT_OFS) ? stat_q :
      (cfg_req.addr == CERR_MASK_OFS) ? mask_reg :
      (cfg_req.addr == CERR_CAPS_OFS) ? (caps_reg | CERR_CAPS_RO1) :
      32'h0000_0000;

  //============================================================
  // read answer one cycle after the request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= cfg_req.rd ? rd_word : rdata_reg;
      rvalid_reg <= cfg_req.rd;
    end
  end

  //============================================================
  // report of unmasked events: message, header log and pointer users
  // one registered stage keeps the outputs glitch free
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      report_reg <= '0;
      msg_reg <= 1'b0;
    end else begin
      report_reg <= cerr_vec_evt(live_vec);
      msg_reg <= |live_vec;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_rvalid = rvalid_reg;
  assign cor_report = report_reg;
  assign cor_msg_req = msg_reg;
  assign link_protocol_fault_fatal_sel = sev_reg[CERR_SEV_DLL_BIT];
  assign crc_check_en = caps_reg[CERR_CAPS_CHK_EN_BIT];
  assign crc_gen_en = caps_reg[CERR_CAPS_GEN_EN_BIT];

  //============================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [31:0] both_hit;
  logic [31:0] masked_only;
  assign both_hit = live_vec & clr_vec;
  assign masked_only = evt_vec & mask_reg & ~stat_q;

  sequence s_read(logic [11:0] ofs);
    cfg_req.rd && cfg_req.addr == ofs ##1 cfg_rvalid;
  endsequence

  property p_sev_ro;
    s_read(CERR_SEV_OFS) |-> cfg_rdata[5] && cfg_rdata[0];
  endproperty
  a_sev_ro: assert property (p_sev_ro) else $error("severity fixed ones lost");

  property p_sev_rsvd;
    s_read(CERR_SEV_OFS) |-> cfg_rdata[11:6] == 6'h00 && cfg_rdata[3:1] == 3'h0;
  endproperty
  a_sev_rsvd: assert property (p_sev_rsvd) else $error("severity reserved bits set");

  property p_dll_wr;
    wr_sev && cfg_req.be[0] && !soft_rst |=>
        link_protocol_fault_fatal_sel == $past(cfg_req.wdata[4]);
  endproperty
  a_dll_wr: assert property (p_dll_wr) else $error("fatal select not written");

  property p_set;
    live_vec != 32'h0000_0000 && !soft_rst |=> (stat_q & $past(live_vec)) == $past(live_vec)
        ##0 cor_msg_req;
  endproperty
  a_set: assert property (p_set) else $error("unmasked event not recorded");

  property p_masked;
    masked_only != 32'h0000_0000 |=> (stat_q & $past(masked_only)) == 32'h0000_0000;
  endproperty
  a_masked: assert property (p_masked) else $error("masked event set a flag");

  property p_set_wins;
    both_hit != 32'h0000_0000 && !soft_rst |=> (stat_q & $past(both_hit)) == $past(both_hit);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a same cycle event");

  property p_w0_keep;
    wr_stat && cfg_req.wdata == 32'h0000_0000 && !soft_rst |=>
        (stat_q & $past(stat_q)) == $past(stat_q);
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("write of zero cleared a flag");

  property p_rsvd;
    (stat_q & ~CERR_STAT_IMPL) == 32'h0000_0000 && (mask_reg & ~CERR_STAT_IMPL) == 32'h0000_0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status or mask bit set");

  property p_soft;
    soft_rst |=> mask_reg == CERR_MASK_RST && stat_q == 32'h0000_0000
        && !crc_check_en && link_protocol_fault_fatal_sel;
  endproperty
  a_soft: assert property (p_soft) else $error("reset pin did not restore defaults");

  property p_caps;
    s_read(CERR_CAPS_OFS) |-> cfg_rdata[7] && cfg_rdata[5];
  endproperty
  a_caps: assert property (p_caps) else $error("crc capability bits not one");

  property p_fep;
    unc_first_load && !soft_rst |=> caps_reg[4:0] == $past(unc_first_pos);
  endproperty
  a_fep: assert property (p_fep) else $error("first error pointer not loaded");

  //============================================================
  // read answer timing and contents
  // the answer slot is fixed at one cycle so software never has to poll
  property p_rvalid;
    cfg_req.rd |=> cfg_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered next cycle");

  property p_rvalid_idle;
    !cfg_req.rd |=> !cfg_rvalid;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("answer without a read");

  property p_rdata_hold;
    !cfg_req.rd |=> $stable(cfg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

  property p_stat_rsvd_rd;
    s_read(CERR_STAT_OFS) |-> (cfg_rdata & ~CERR_STAT_IMPL) == 32'h0000_0000;
  endproperty
  a_stat_rsvd_rd: assert property (p_stat_rsvd_rd) else $error("status reserved bit read one");

  property p_mask_rsvd_rd;
    s_read(CERR_MASK_OFS) |-> (cfg_rdata & ~CERR_STAT_IMPL) == 32'h0000_0000;
  endproperty
  a_mask_rsvd_rd: assert property (p_mask_rsvd_rd) else $error("mask reserved bit read one");

  property p_caps_rsvd_rd;
    s_read(CERR_CAPS_OFS) |-> cfg_rdata[31:9] == 23'h00_0000;
  endproperty
  a_caps_rsvd_rd: assert property (p_caps_rsvd_rd) else $error("control reserved bit read one");

  property p_sev_out;
    s_read(CERR_SEV_OFS) |-> cfg_rdata[CERR_SEV_DLL_BIT] == $past(link_protocol_fault_fatal_sel);
  endproperty
  a_sev_out: assert property (p_sev_out) else $error("fatal select differs from register");

  property p_crc_out;
    s_read(CERR_CAPS_OFS) |-> cfg_rdata[8] == $past(crc_check_en)
        && cfg_rdata[6] == $past(crc_gen_en);
  endproperty
  a_crc_out: assert property (p_crc_out) else $error("crc enables differ from register");

  //============================================================
  // register hold and reset
  // a register may only move on its own write, a pointer load or a reset pin
  property p_sev_keep;
    !wr_sev && !soft_rst |=> $stable(sev_reg);
  endproperty
  a_sev_keep: assert property (p_sev_keep) else $error("severity moved without a write");

  property p_mask_keep;
    !wr_mask && !soft_rst |=> $stable(mask_reg);
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("mask moved without a write");

  property p_mask_wr;
    wr_mask && cfg_req.be == 4'hF && !soft_rst |=>
        mask_reg == ($past(cfg_req.wdata) & CERR_STAT_IMPL);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write not taken");

  property p_caps_keep;
    !wr_caps && !unc_first_load && !soft_rst |=> $stable(caps_reg);
  endproperty
  a_caps_keep: assert property (p_caps_keep) else $error("control moved without a cause");

  property p_fep_keep;
    !unc_first_load && !soft_rst |=> $stable(caps_reg[4:0]);
  endproperty
  a_fep_keep: assert property (p_fep_keep) else $error("pointer moved without a load");

  property p_soft_regs;
    soft_rst |=> sev_reg == (CERR_SEV_RST & CERR_SEV_RW)
        && caps_reg == (CERR_CAPS_RST & CERR_CAPS_RW);
  endproperty
  a_soft_regs: assert property (p_soft_regs) else $error("reset pin left a register dirty");

  //============================================================
  // flag life cycle and report
  // flags are sticky: only a write of one or a reset pin may drop them
  property p_sticky;
    !wr_stat && !soft_rst |=> (stat_q & $past(stat_q)) == $past(stat_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without a clear");

  property p_clear;
    wr_stat && !soft_rst |=> (stat_q & $past(clr_vec & ~live_vec)) == 32'h0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("write of one did not clear");

  property p_report;
    live_vec != 32'h0000_0000 |=> cerr_evt_vec(cor_report) == $past(live_vec);
  endproperty
  a_report: assert property (p_report) else $error("report differs from unmasked events");

  property p_report_idle;
    live_vec == 32'h0000_0000 |=> !cor_msg_req && cor_report == '0;
  endproperty
  a_report_idle: assert property (p_report_idle) else $error("report without an event");
endmodule

// *** testbench/cerr_det_model.sv ***
/*
  Detector model: turns a bench request into event pulses on core_clk.
  Assumes the bench raises a request for one cycle at a time.
*/
`timescale 1ns/10ps
module cerr_det_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // request from the bench
  input wire logic fire,
  input wire cerr_pkg::cerr_evt_t fire_vec,
  // pulses to the block
  output cerr_pkg::cerr_evt_t evt_out
);
  import cerr_pkg::*;
  //============================================================
  // registered so pulses leave just after an edge, like real detectors
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evt_out <= '0;
    end else begin
      evt_out <= fire ? fire_vec : '0;
    end
  end
endmodule

// *** testbench/testbench.sv ***
/*
  Self-checking bench for the correctable error block.
  Assumes the design files are compiled first; no checker file is used.
*/
`timescale 1ns/10ps
module testbench;
  import cerr_pkg::*;
  //============================================================
  // signals
  logic core_clk, rst, link_reset, global_reset_input, fire;
  logic unc_first_load, cfg_rvalid, cor_msg_req, fatal_sel, chk_en, gen_en;
  logic [4:0] unc_first_pos;
  logic [31:0] cfg_rdata, r, acc, m;
  cerr_cfg_req_t cfg_req;
  cerr_evt_t fire_vec, evt_in, cor_report, e;
  logic [31:0] rd_q[$];
  cerr_evt_t rep_q[$];
  int fails, tests_run, seed, i;

  cerr_det_model det (.core_clk(core_clk), .rst(rst), .fire(fire), .fire_vec(fire_vec),
    .evt_out(evt_in));
  cerr_top dut (.core_clk(core_clk), .rst(rst), .link_reset(link_reset),
    .global_reset_input(global_reset_input), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .evt_in(evt_in), .unc_first_load(unc_first_load),
    .unc_first_pos(unc_first_pos), .cor_report(cor_report), .cor_msg_req(cor_msg_req),
    .link_protocol_fault_fatal_sel(fatal_sel), .crc_check_en(chk_en), .crc_gen_en(gen_en));

  //============================================================
  // clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  //============================================================
  // helpers: own bit mapping, kept apart from the design's
  function automatic logic [31:0] st_of(input cerr_evt_t v);
    st_of = {18'h00000, v.advisory, v.replay_tmo, 3'h0, v.replay_roll, v.corrupt_link_packet_flag,
      v.corrupt_transaction_packet_flag, 5'h00, v.rx_err};
  endfunction

  function automatic cerr_evt_t msk_of(input logic [31:0] k);
    msk_of = {k[13], k[12], k[8], k[7], k[6], k[0]};
  endfunction

  task automatic chk_rd(input string n, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, exp, got);
    end
  endtask

  task automatic chk_rep(input string n, input cerr_evt_t exp, input cerr_evt_t got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, exp, got);
    end
  endtask

  // level outputs are looked at well after the write that moves them
  task automatic chk_lvl(input string n, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %b got %b", n, exp, got);
    end
  endtask

  // one request, then an idle cycle so strobes never merge
  task automatic cfg(input logic rd, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cfg_req <= '{rd, ~rd, a, 4'hF, d};
    if (rd) rd_q.push_back(d);
    @(posedge core_clk);
    cfg_req <= '0;
  endtask

  // event pulse; clr, when nonzero, is a write-one-to-clear landing on the same edge
  task automatic pulse(input cerr_evt_t v, input logic [31:0] k, input logic [31:0] clr);
    @(posedge core_clk);
    fire <= 1'b1;
    fire_vec <= v;
    if ((v & ~msk_of(k)) !== '0) rep_q.push_back(v & ~msk_of(k));
    @(posedge core_clk);
    fire <= 1'b0;
    if (clr !== 32'h0000_0000) begin
      cfg_req <= '{1'b0, 1'b1, CERR_STAT_OFS, 4'hF, clr};
      @(posedge core_clk);
      cfg_req <= '0;
    end
  endtask

  task automatic defaults();
    cfg(1'b1, CERR_SEV_OFS, 32'h0006_2031);
    cfg(1'b1, CERR_STAT_OFS, 32'h0000_0000);
    cfg(1'b1, CERR_MASK_OFS, 32'h0000_2000);
    cfg(1'b1, CERR_CAPS_OFS, 32'h0000_00A0);
  endtask

  task automatic summarize();
    if (rd_q.size() != 0 || rep_q.size() != 0) fails++;
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  //============================================================
  // monitor: each answer takes the oldest note; an answer with no note is an error
  always @(posedge core_clk) begin
    if (!rst && cfg_rvalid === 1'b1) begin
      if (rd_q.size() == 0) chk_rd("cfg_rdata_extra", 32'h0000_0000, 32'hFFFF_FFFF);
      else chk_rd("cfg_rdata", rd_q.pop_front(), cfg_rdata);
    end
    if (!rst && cor_msg_req === 1'b1) begin
      if (rep_q.size() == 0) chk_rep("cor_report_extra", '0, cor_report);
      else chk_rep("cor_report", rep_q.pop_front(), cor_report);
    end
  end

  //============================================================
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    summarize();
  end

  //============================================================
  // main sequence
  initial begin
    seed = 71020;
    fails = 0;
    tests_run = 0;
    rst = 1'b1;
    link_reset = 1'b0;
    global_reset_input = 1'b0;
    cfg_req = '0;
    fire = 1'b0;
    fire_vec = '0;
    unc_first_load = 1'b0;
    unc_first_pos = 5'h00;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    defaults();
    chk_lvl("fatal_sel", 1'b1, fatal_sel);
    chk_lvl("crc_check_en", 1'b0, chk_en);
    chk_lvl("crc_gen_en", 1'b0, gen_en);
    cfg(1'b0, CERR_SEV_OFS, 32'hFFFF_FFFF);
    cfg(1'b1, CERR_SEV_OFS, 32'h001F_F031);
    chk_lvl("fatal_sel", 1'b1, fatal_sel);
    cfg(1'b0, CERR_SEV_OFS, 32'h0000_0000);
    cfg(1'b1, CERR_SEV_OFS, 32'h0000_0021);
    chk_lvl("fatal_sel", 1'b0, fatal_sel);
    cfg(1'b0, CERR_MASK_OFS, 32'hFFFF_FFFF);
    cfg(1'b1, CERR_MASK_OFS, 32'h0000_31C1);
    // only byte 1 is enabled, so bits 13, 12 and 8 clear and the rest stay
    @(posedge core_clk);
    cfg_req <= '{1'b0, 1'b1, CERR_MASK_OFS, 4'h2, 32'h0000_0000};
    @(posedge core_clk);
    cfg_req <= '0;
    cfg(1'b1, CERR_MASK_OFS, 32'h0000_00C1);
    cfg(1'b0, CERR_MASK_OFS, 32'h0000_0000);
    acc = 32'h0000_0000;
    for (i = 0; i < 6; i++) begin
      e = 6'h01 << i;
      pulse(e, 32'h0000_0000, 32'h0000_0000);
      acc = acc | st_of(e);
      cfg(1'b1, CERR_STAT_OFS, acc);
    end
    cfg(1'b0, CERR_STAT_OFS, 32'h0000_0000);
    cfg(1'b1, CERR_STAT_OFS, 32'h0000_31C1);
    cfg(1'b0, CERR_STAT_OFS, 32'hFFFF_FFFF);
    cfg(1'b1, CERR_STAT_OFS, 32'h0000_0000);
    cfg(1'b0, CERR_MASK_OFS, 32'hFFFF_FFFF);
    pulse(6'h3F, 32'hFFFF_FFFF, 32'h0000_0000);
    cfg(1'b1, CERR_STAT_OFS, 32'h0000_0000);
    cfg(1'b0, CERR_MASK_OFS, 32'h0000_0000);
    pulse(6'h20, 32'h0000_0000, 32'h0000_0000);
    pulse(6'h20, 32'h0000_0000, 32'h0000_2000);
    cfg(1'b1, CERR_STAT_OFS, 32'h0000_2000);
    cfg(1'b0, CERR_STAT_OFS, 32'hFFFF_FFFF);
    // random masks against random event sets
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      m = r & 32'h0000_31C1;
      r = $random(seed);
      e = r[5:0];
      cfg(1'b0, CERR_MASK_OFS, m);
      pulse(e, m, 32'h0000_0000);
      cfg(1'b1, CERR_STAT_OFS, st_of(e) & ~m);
      cfg(1'b0, CERR_STAT_OFS, 32'hFFFF_FFFF);
    end
    @(posedge core_clk);
    unc_first_load <= 1'b1;
    unc_first_pos <= 5'h13;
    @(posedge core_clk);
    unc_first_load <= 1'b0;
    cfg(1'b0, CERR_CAPS_OFS, 32'hFFFF_FFFF);
    cfg(1'b1, CERR_CAPS_OFS, 32'h0000_01F3);
    chk_lvl("crc_check_en", 1'b1, chk_en);
    chk_lvl("crc_gen_en", 1'b1, gen_en);
    cfg(1'b0, CERR_CAPS_OFS, 32'h0000_0100);
    cfg(1'b1, CERR_CAPS_OFS, 32'h0000_01B3);
    chk_lvl("crc_check_en", 1'b1, chk_en);
    chk_lvl("crc_gen_en", 1'b0, gen_en);
    cfg(1'b0, 12'h11C, 32'hFFFF_FFFF);
    cfg(1'b1, 12'h11C, 32'h0000_0000);
    // dirty severity, mask and status, then each reset pin must restore defaults
    for (i = 0; i < 2; i++) begin
      cfg(1'b0, CERR_SEV_OFS, 32'hFFFF_FFFF);
      cfg(1'b0, CERR_MASK_OFS, 32'h0000_0000);
      pulse(6'h3F, 32'h0000_0000, 32'h0000_0000);
      @(posedge core_clk);
      link_reset <= (i == 0);
      global_reset_input <= (i == 1);
      repeat (2) @(posedge core_clk);
      // a write while the pin is held must be dropped
      cfg(1'b0, CERR_MASK_OFS, 32'h0000_0000);
      link_reset <= 1'b0;
      global_reset_input <= 1'b0;
      repeat (4) @(posedge core_clk);
      defaults();
      chk_lvl("fatal_sel", 1'b1, fatal_sel);
      chk_lvl("crc_check_en", 1'b0, chk_en);
      chk_lvl("crc_gen_en", 1'b0, gen_en);
    end
    repeat (4) @(posedge core_clk);
    summarize();
  end
endmodule
